// ===== design/adc_pkg.sv
`default_nettype none
package adc_pkg;
  // Timing figures in nanoseconds, and cycle counts derived from them.
  localparam int CLK_NS = 10;
  localparam int CNT_W = 12;
  localparam int DATA_W = 10;
  localparam int CONVERT_MIN_NS = 500;
  localparam int RESET_TYP_NS = 1000;
  localparam int CONV_TYP_NS = 20000;
  localparam int RESULT_WAIT_NS = 30000;
  localparam int ACCESS_MAX_NS = 250;
  localparam int HOLD_MIN_NS = 50;
  localparam int FLOAT_TYP_NS = 100;
  localparam int FLOAT_MAX_NS = 200;
  localparam int ACQ_MIN_NS = 10000;
  // Least and longest times round up, typical times round down.
  localparam logic [CNT_W-1:0] CONVERT_CYC =
    CNT_W'((CONVERT_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] RESET_CYC = CNT_W'(RESET_TYP_NS / CLK_NS);
  localparam logic [CNT_W-1:0] BIT_CYC =
    CNT_W'(CONV_TYP_NS / CLK_NS / DATA_W);
  localparam logic [CNT_W-1:0] RESULT_WAIT_CYC =
    CNT_W'((RESULT_WAIT_NS + CLK_NS - 1) / CLK_NS);
  // Two synchroniser stages at each end plus the output register at each end.
  localparam logic [CNT_W-1:0] SYNC_MARGIN_CYC = 12'h006;
  localparam logic [CNT_W-1:0] ACCESS_CYC =
    CNT_W'((ACCESS_MAX_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] FLOAT_CYC =
    CNT_W'((HOLD_MIN_NS + FLOAT_TYP_NS) / CLK_NS);
  localparam logic [CNT_W-1:0] RELEASE_CYC =
    CNT_W'((HOLD_MIN_NS + FLOAT_MAX_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] ACQ_CYC =
    CNT_W'((ACQ_MIN_NS + CLK_NS - 1) / CLK_NS);
  // Bus locations and reset values.
  localparam logic ADDR_BASE = 1'b0;
  localparam logic ADDR_ABOVE = 1'b1;
  localparam logic [DATA_W-1:0] RESULT_RST = 10'h000;
  localparam logic [DATA_W-1:0] MSB_TRIAL = 10'h200;
  localparam logic [3:0] MSB_IDX = 4'h9;
  typedef enum logic [1:0] {CV_IDLE, CV_CLEAR, CV_ARMED, CV_RUN} conv_state_t;
  typedef enum logic [2:0] {
    H_IDLE, H_START, H_WAIT, H_READ, H_RELEASE
  } host_state_t;
endpackage
`default_nettype wire

// ===== design/adc_link_if.sv
`timescale 1ns/1ps
`default_nettype none
// Pins between the converter and its bus controller. The converter is the
// only driver of the data pins, so the controller reads data_out and never reads
// data_oe_upper or data_oe_lower; it times the sample from its own byte enables.
interface adc_link_if;
  logic convert_start; // Start pulse, active high.
  logic upper_byte_output_enable_n; // Upper byte enable, active low.
  logic lower_byte_output_enable_n; // Lower byte enable, active low.
  logic conversion_done_n; // Low when a result is ready.
  logic [9:0] data_out; // Value the converter drives.
  logic data_oe_upper; // High while bits 9..2 are driven.
  logic data_oe_lower; // High while bits 1..0 are driven.
  modport converter (
    input convert_start, upper_byte_output_enable_n,
    input lower_byte_output_enable_n,
    output conversion_done_n, data_out, data_oe_upper, data_oe_lower
  );
  modport controller (
    output convert_start, upper_byte_output_enable_n,
    output lower_byte_output_enable_n,
    input conversion_done_n, data_out, data_oe_upper, data_oe_lower
  );
endinterface
`default_nettype wire

// ===== design/sync2.sv
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser; only the second stage leaves this module.
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic [W-1:0] d, // Asynchronous inputs.
  output logic [W-1:0] q // Synchronised copy.
);
  logic [W-1:0] meta_r; // First stage, read by q alone.
  // Reset to zero; callers see every pin low for two cycles after reset.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ===== design/adc_converter_end.sv
`timescale 1ns/1ps
`default_nettype none
// Digital side of a successive-approximation converter.
module adc_converter_end (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  adc_link_if.converter link, // Pins towards the controller.
  input wire logic [9:0] analog_level // Digitised stand-in for the input.
);
  //////////////////////////////////////////////////////////////////////////
  logic [2:0] pins_s; // Convert, upper enable, lower enable, synchronised.
  logic convert_q_r; // Previous synchronised convert level.
  logic convert_rise; // Convert went high.
  logic convert_fall; // Convert went low.
  adc_pkg::conv_state_t state_r; // Converter sequence state.
  logic [adc_pkg::CNT_W-1:0] cnt_r; // Cycle counter of the current phase.
  logic [3:0] bit_idx_r; // Bit under trial.
  logic [9:0] approximation_register_r; // Running approximation.
  logic [9:0] approximation_register_nxt; // Value after a bit decision.
  logic bit_end; // Last cycle of a bit trial.
  logic done_n_r; // Done line.
  logic [9:0] data_r; // Value on the data pins.
  logic [1:0] oe_r; // Lane drive, index 1 upper, 0 lower.

  sync2 #(.W(3)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({link.convert_start, link.upper_byte_output_enable_n,
        link.lower_byte_output_enable_n}),
    .q(pins_s)
  );

  // Edges are taken from the synchronised level only.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      convert_q_r <= 1'b0;
    end else begin
      convert_q_r <= pins_s[2];
    end
  end
  assign convert_rise = pins_s[2] & ~convert_q_r;
  assign convert_fall = ~pins_s[2] & convert_q_r;
  assign bit_end = (state_r == adc_pkg::CV_RUN) &&
                   (cnt_r == adc_pkg::BIT_CYC - 12'h001);

  //////////////////////////////////////////////////////////////////////////
  // Sequence: a rising start clears, a falling start runs the trials.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= adc_pkg::CV_IDLE;
      cnt_r <= '0;
      bit_idx_r <= '0;
    end else if (convert_rise) begin
      state_r <= adc_pkg::CV_CLEAR;
      cnt_r <= '0;
    end else begin
      case (state_r)
        adc_pkg::CV_CLEAR, adc_pkg::CV_ARMED: begin
          cnt_r <= cnt_r + 12'h001;
          if (convert_fall) begin
            // Trials start on the falling edge only.
            state_r <= adc_pkg::CV_RUN;
            cnt_r <= '0;
            bit_idx_r <= adc_pkg::MSB_IDX;
          end else if (cnt_r == adc_pkg::RESET_CYC - 12'h001) begin
            state_r <= adc_pkg::CV_ARMED;
          end
        end
        adc_pkg::CV_RUN: begin
          cnt_r <= cnt_r + 12'h001;
          if (bit_end) begin
            cnt_r <= '0;
            if (bit_idx_r == 4'h0) begin
              state_r <= adc_pkg::CV_IDLE;
            end else begin
              bit_idx_r <= bit_idx_r - 4'h1;
            end
          end
        end
        default: begin
          cnt_r <= '0;
        end
      endcase
    end
  end

  // Keep the trial bit if it does not overshoot, then try the next one.
  always_comb begin
    approximation_register_nxt = approximation_register_r;
    if (approximation_register_r > analog_level) begin
      approximation_register_nxt[bit_idx_r] = 1'b0;
    end
    if (bit_idx_r != 4'h0) begin
      approximation_register_nxt[bit_idx_r - 4'h1] = 1'b1;
    end
  end

  // The old result is discarded on every rising start.
  always_ff @(posedge clk_sys) begin
    if (rst || convert_rise) begin
      approximation_register_r <= adc_pkg::RESULT_RST;
    end else if (convert_fall && (state_r == adc_pkg::CV_CLEAR ||
                                  state_r == adc_pkg::CV_ARMED)) begin
      approximation_register_r <= adc_pkg::MSB_TRIAL;
    end else if (bit_end) begin
      approximation_register_r <= approximation_register_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Done rises once the clear time has passed, or at once if the start
  // falls earlier, and falls when the last bit is decided.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_n_r <= 1'b0;
    end else if (state_r == adc_pkg::CV_CLEAR && !convert_rise &&
                 (convert_fall ||
                  cnt_r == adc_pkg::RESET_CYC - 12'h001)) begin
      done_n_r <= 1'b1;
    end else if (bit_end && bit_idx_r == 4'h0) begin
      done_n_r <= 1'b0;
    end
  end

  // Pins follow the register while any lane is enabled, partial or not.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      data_r <= adc_pkg::RESULT_RST;
    end else if (!pins_s[1] || !pins_s[0]) begin
      data_r <= approximation_register_r;
    end
  end

  // Each lane drives while enabled, holds after release, then floats.
  genvar lane;
  generate
    for (lane = 0; lane < 2; lane++) begin : g_lane
      logic [adc_pkg::CNT_W-1:0] hold_cnt_r; // Cycles since release.
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          oe_r[lane] <= 1'b0;
          hold_cnt_r <= '0;
        end else if (!pins_s[lane]) begin
          oe_r[lane] <= 1'b1;
          hold_cnt_r <= '0;
        end else if (oe_r[lane]) begin
          hold_cnt_r <= hold_cnt_r + 12'h001;
          if (hold_cnt_r == adc_pkg::FLOAT_CYC - 12'h001) begin
            oe_r[lane] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  assign link.conversion_done_n = done_n_r;
  assign link.data_out = data_r;
  assign link.data_oe_upper = oe_r[1];
  assign link.data_oe_lower = oe_r[0];
endmodule
`default_nettype wire

// ===== design/adc_bus_controller.sv
`timescale 1ns/1ps
`default_nettype none
// What this block and the converter do
// - Start pulse high at least 500 ns.
// - Rising start clears logic, done goes high.
// - Done high within 1.5 us of start.
// - Conversion runs from the falling start.
// - Conversion takes 10 to 30 us.
// - Byte enables stay high during conversion.
// - Early enable shows the partial value.
// - Each byte enable gates its own lane.
// - Done low means result is ready.
// - Wait access time before sampling data.
// - Data held, then floats after release.
// - Address with write starts, with read enables.
// - Two adjacent locations on byte bus.
// - Base write starts, base read upper byte.
// - Upper write ignored, upper read lower byte.
// - Timer mode waits 30 us before reading.
// - Or watch done, interrupt on its fall.
// - Wait 10 us after done falls.
module adc_bus_controller (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  adc_link_if.controller link, // Pins towards the converter.
  input wire logic bus_write, // Write request, held with bus_addr.
  input wire logic bus_read, // Read request, held with bus_addr.
  input wire logic bus_addr, // 0 is the base location, 1 the one above.
  input wire logic wait_for_done, // 1 watches done, 0 uses the timer.
  output logic bus_ready, // Requests are taken while high.
  output logic bus_ack, // One-cycle pulse when a request finishes.
  output logic [7:0] bus_rdata, // Byte of the last read.
  output logic eoc_irq // One-cycle pulse on done falling.
);
  //////////////////////////////////////////////////////////////////////////
  logic [10:0] pins_s; // Done line and data pins, synchronised.
  logic done_s; // Synchronised done line.
  logic [9:0] data_s; // Synchronised data pins.
  logic done_q_r; // Previous synchronised done level.
  logic done_fall; // Done went low.
  logic take; // A request is taken this cycle.
  adc_pkg::host_state_t state_r; // Controller state.
  logic [adc_pkg::CNT_W-1:0] cnt_r; // Cycle counter of the current phase.
  logic [adc_pkg::CNT_W-1:0] recover_cnt_r; // Sampler acquire time left.
  logic seen_high_r; // Done was seen high since the last write.
  logic read_upper_r; // The read in flight is of the base location.
  logic convert_r; // Start pin.
  logic upper_en_n_r; // Upper byte enable pin.
  logic lower_en_n_r; // Lower byte enable pin.
  logic ready_r; // Registered ready.
  logic ack_r; // Registered acknowledge.
  logic [7:0] rdata_r; // Registered read byte.
  logic irq_r; // Registered end-of-conversion pulse.

  sync2 #(.W(11)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d({link.conversion_done_n, link.data_out}),
    .q(pins_s)
  );
  assign done_s = pins_s[10];
  assign data_s = pins_s[9:0];

  // Done edge from the synchronised level.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      done_q_r <= 1'b0;
    end else begin
      done_q_r <= done_s;
    end
  end
  assign done_fall = done_q_r & ~done_s;

  // A request held while ready is high is taken on that edge.
  assign take = ready_r & (bus_write | bus_read);

  //////////////////////////////////////////////////////////////////////////
  // Ready is one cycle late on purpose: it never opens early, so a request
  // can never be taken in a state that cannot serve it.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (state_r == adc_pkg::H_IDLE) && !take && !done_fall &&
                 (recover_cnt_r == '0);
    end
  end

  // Time for a done-controlled sampler to acquire before the next start.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      recover_cnt_r <= '0;
    end else if (done_fall) begin
      recover_cnt_r <= adc_pkg::ACQ_CYC;
    end else if (recover_cnt_r != '0) begin
      recover_cnt_r <= recover_cnt_r - 12'h001;
    end
  end

  // Done must be seen high before its fall counts as the end.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seen_high_r <= 1'b0;
    end else if (take && bus_write) begin
      seen_high_r <= 1'b0;
    end else if (done_s) begin
      seen_high_r <= 1'b1;
    end
  end

  // The end-of-conversion interrupt follows every fall of done.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= done_fall;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Main sequence. Reads are only served from idle, and idle is left for
  // the start only after the whole conversion wait, so the enables can
  // never fall while a conversion is running.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= adc_pkg::H_IDLE;
      cnt_r <= '0;
      convert_r <= 1'b0;
      upper_en_n_r <= 1'b1;
      lower_en_n_r <= 1'b1;
      read_upper_r <= 1'b0;
      ack_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      ack_r <= 1'b0;
      case (state_r)
        adc_pkg::H_IDLE: begin
          cnt_r <= '0;
          if (take && bus_write) begin
            if (bus_addr == adc_pkg::ADDR_BASE) begin
              // Any written value starts the converter.
              convert_r <= 1'b1;
              state_r <= adc_pkg::H_START;
            end else begin
              // The upper location ignores writes.
              ack_r <= 1'b1;
            end
          end else if (take) begin
            // Address plus read opens one byte lane.
            read_upper_r <= (bus_addr == adc_pkg::ADDR_BASE);
            upper_en_n_r <= (bus_addr != adc_pkg::ADDR_BASE);
            lower_en_n_r <= (bus_addr != adc_pkg::ADDR_ABOVE);
            state_r <= adc_pkg::H_READ;
          end
        end
        adc_pkg::H_START: begin
          cnt_r <= cnt_r + 12'h001;
          // Width counted in whole cycles, rounded up.
          if (cnt_r == adc_pkg::CONVERT_CYC - 12'h001) begin
            convert_r <= 1'b0;
            cnt_r <= '0;
            state_r <= adc_pkg::H_WAIT;
          end
        end
        adc_pkg::H_WAIT: begin
          cnt_r <= cnt_r + 12'h001;
          if (wait_for_done) begin
            if (seen_high_r && !done_s) begin
              ack_r <= 1'b1;
              state_r <= adc_pkg::H_IDLE;
            end
          end else if (cnt_r == adc_pkg::RESULT_WAIT_CYC - 12'h001) begin
            ack_r <= 1'b1;
            state_r <= adc_pkg::H_IDLE;
          end
        end
        adc_pkg::H_READ: begin
          cnt_r <= cnt_r + 12'h001;
          // Access time plus both synchronisers before sampling.
          if (cnt_r == adc_pkg::ACCESS_CYC + adc_pkg::SYNC_MARGIN_CYC -
                       12'h001) begin
            if (read_upper_r) begin
              rdata_r <= data_s[9:2];
            end else begin
              // Only the top two bits carry data; the rest are masked.
              rdata_r <= {data_s[1:0], 6'h00};
            end
            upper_en_n_r <= 1'b1;
            lower_en_n_r <= 1'b1;
            ack_r <= 1'b1;
            cnt_r <= '0;
            state_r <= adc_pkg::H_RELEASE;
          end
        end
        adc_pkg::H_RELEASE: begin
          cnt_r <= cnt_r + 12'h001;
          // Let the data pins float before anything else happens.
          if (cnt_r == adc_pkg::RELEASE_CYC - 12'h001) begin
            cnt_r <= '0;
            state_r <= adc_pkg::H_IDLE;
          end
        end
        default: begin
          state_r <= adc_pkg::H_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  assign link.convert_start = convert_r;
  assign link.upper_byte_output_enable_n = upper_en_n_r;
  assign link.lower_byte_output_enable_n = lower_en_n_r;
  assign bus_ready = ready_r;
  assign bus_ack = ack_r;
  assign bus_rdata = rdata_r;
  assign eoc_irq = irq_r;
endmodule
`default_nettype wire

// ===== testbench/adc_link_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the pins between the converter and its controller.
module adc_link_asserts (
  input wire logic clk_sys, // System clock.
  input wire logic rst, // Synchronous reset, active high.
  input wire logic convert_start, // Start pulse.
  input wire logic upper_byte_output_enable_n, // Upper byte enable.
  input wire logic lower_byte_output_enable_n, // Lower byte enable.
  input wire logic conversion_done_n, // Done line, active low.
  input wire logic [9:0] data_out, // Converter data.
  input wire logic data_oe_upper, // Upper lane driven.
  input wire logic data_oe_lower // Lower lane driven.
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  logic [11:0] start_cnt_r; // Cycles the start line has been high.
  logic [11:0] start_cnt_nxt; // Next value of the count.
  logic run_r; // A conversion is running since the start fell.
  logic done_q_r; // Done line one cycle earlier.
  logic [11:0] run_cnt_r; // Cycles since the start fell.
  // The count restarts whenever the line is low, so a fall sees the width.
  always_comb begin
    start_cnt_nxt = convert_start ? start_cnt_r + 12'h001 : 12'h000;
  end
  // Twelve bits cannot wrap within any legal pulse.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      start_cnt_r <= 12'h000;
    end else begin
      start_cnt_r <= start_cnt_nxt;
    end
  end
  // The conversion window is too long for a delay range, so it is counted
  // here. The count stops at its top, so a hung conversion cannot wrap
  // back into the legal window.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      run_r <= 1'b0;
      done_q_r <= 1'b0;
      run_cnt_r <= 12'h000;
    end else begin
      done_q_r <= conversion_done_n;
      if (!convert_start && start_cnt_r != 12'h000) begin
        // The start has just fallen: the trials begin.
        run_r <= 1'b1;
        run_cnt_r <= 12'h001;
      end else if (run_r && done_q_r && !conversion_done_n) begin
        // Done has fallen: the conversion is over.
        run_r <= 1'b0;
      end else if (run_r && run_cnt_r != 12'hFFF) begin
        run_cnt_r <= run_cnt_r + 12'h001;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_start_width: assert property (
    $fell(convert_start) |-> start_cnt_r >= adc_pkg::CONVERT_CYC)
    else $error("start pulse too short");
  a_done_rises: assert property (
    $rose(convert_start) |-> ##[1:150] conversion_done_n)
    else $error("done line not raised after start");
  a_conv_window: assert property (
    run_r && done_q_r && !conversion_done_n |->
      run_cnt_r >= 12'h3E8 && run_cnt_r <= 12'hBB8)
    else $error("conversion time out of range");
  a_conv_bound: assert property (
    run_r |-> run_cnt_r <= 12'hBB8)
    else $error("conversion did not end in time");
  a_enables_idle: assert property (
    conversion_done_n |->
      upper_byte_output_enable_n && lower_byte_output_enable_n)
    else $error("byte enable low during conversion");
  a_upper_on: assert property (
    $fell(upper_byte_output_enable_n) |-> ##[1:5] data_oe_upper)
    else $error("upper lane not driven in time");
  a_lower_on: assert property (
    $fell(lower_byte_output_enable_n) |-> ##[1:5] data_oe_lower)
    else $error("lower lane not driven in time");
  a_upper_float: assert property (
    $rose(upper_byte_output_enable_n) |->
      data_oe_upper [*5] ##[1:25] !data_oe_upper)
    else $error("upper lane hold or float wrong");
  a_lower_float: assert property (
    $rose(lower_byte_output_enable_n) |->
      data_oe_lower [*5] ##[1:25] !data_oe_lower)
    else $error("lower lane hold or float wrong");
  a_result_stable: assert property (
    !conversion_done_n && $past(!conversion_done_n) && data_oe_upper &&
      $past(data_oe_upper) |-> $stable(data_out))
    else $error("result moved while done is low");
endmodule
`default_nettype wire

// ===== testbench/tb_adc_conversion_bus_control.sv
`timescale 1ns/1ps
`default_nettype none
// Both ends joined; the bench drives the controller's user bus.
module tb_adc_conversion_bus_control;
  typedef struct {
    logic is_read; // Read or write.
    logic adr; // Location used.
    logic [7:0] value; // Byte read, or start expected for a write.
  } note_t;
  logic clk_sys; // System clock.
  logic rst; // Reset.
  logic bus_write; // Write request.
  logic bus_read; // Read request.
  logic bus_addr; // Location.
  logic wait_for_done; // Completion mode.
  logic bus_ready; // Requests accepted.
  logic bus_ack; // Request finished.
  logic [7:0] bus_rdata; // Read byte.
  logic eoc_irq; // End of conversion.
  logic [9:0] analog_level; // Value to convert.
  logic [9:0] data_bus; // Resolved data pins.
  logic seen_start; // Start line seen high since last ack.
  note_t notes[$]; // Expected results, oldest first.
  int miscompares; // Mismatches.
  int checked; // Comparisons made.
  int eoc_cnt; // End-of-conversion pulses.
  int wt; // Cycles waited before a take.
  int lat; // Cycles from take to ack.
  logic [9:0] lvl; // Level of this round.
  ////////////////////////////////////////////////////////////////////////////
  adc_link_if adc_link_if_inst ();
  adc_converter_end adc_converter_end_inst (.clk_sys(clk_sys), .rst(rst),
    .link(adc_link_if_inst.converter), .analog_level(analog_level));
  adc_bus_controller adc_bus_controller_inst (.clk_sys(clk_sys),
    .rst(rst), .link(adc_link_if_inst.controller), .bus_write(bus_write),
    .bus_read(bus_read), .bus_addr(bus_addr),
    .wait_for_done(wait_for_done), .bus_ready(bus_ready),
    .bus_ack(bus_ack), .bus_rdata(bus_rdata), .eoc_irq(eoc_irq));
  adc_link_asserts adc_link_asserts_inst (.clk_sys(clk_sys), .rst(rst),
    .convert_start(adc_link_if_inst.convert_start),
    .upper_byte_output_enable_n(adc_link_if_inst.upper_byte_output_enable_n),
    .lower_byte_output_enable_n(adc_link_if_inst.lower_byte_output_enable_n),
    .conversion_done_n(adc_link_if_inst.conversion_done_n),
    .data_out(adc_link_if_inst.data_out),
    .data_oe_upper(adc_link_if_inst.data_oe_upper),
    .data_oe_lower(adc_link_if_inst.data_oe_lower));
  // Undriven lanes float, so a stale value can never pass a check.
  assign data_bus = {adc_link_if_inst.data_oe_upper ?
    adc_link_if_inst.data_out[9:2] : 8'hZZ,
    adc_link_if_inst.data_oe_lower ? adc_link_if_inst.data_out[1:0] : 2'hZ};
  // Free-running clock, 10 ns period.
  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [9:0] seen,
                       input logic [9:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // One bus request: held until taken, then released and acked.
  task automatic request(input logic wr, input logic adr,
                         input logic [7:0] exp);
    note_t nt;
    nt.is_read = !wr;
    nt.adr = adr;
    nt.value = exp;
    notes.push_back(nt);
    bus_write <= wr;
    bus_read <= !wr;
    bus_addr <= adr;
    wt = 0;
    do begin
      @(posedge clk_sys);
      wt++;
    end while (bus_ready !== 1'b1 && wt < 5000);
    bus_write <= 1'b0;
    bus_read <= 1'b0;
    lat = 0;
    do begin
      @(posedge clk_sys);
      lat++;
    end while (bus_ack !== 1'b1 && lat < 6000);
    // A hang is a failure; stop here rather than cascade.
    if (wt >= 5000 || lat >= 6000) begin
      miscompares++;
      give_verdict();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Takes the oldest note at each ack and compares it with what was seen.
  always @(posedge clk_sys) begin
    if (adc_link_if_inst.convert_start === 1'b1) begin
      seen_start = 1'b1;
    end
    if (eoc_irq === 1'b1) begin
      eoc_cnt++;
    end
    if (rst === 1'b0 && bus_ack === 1'b1 && notes.size() > 0) begin
      note_t nt;
      nt = notes.pop_front();
      if (!nt.is_read) begin
        check("start", {9'h000, seen_start}, {2'h0, nt.value});
      end else if (nt.adr == adc_pkg::ADDR_BASE) begin
        check("rdata", {2'h0, bus_rdata}, {2'h0, nt.value});
        check("upper", {2'h0, data_bus[9:2]}, {2'h0, nt.value});
      end else begin
        check("rdata", {2'h0, bus_rdata}, {2'h0, nt.value});
        check("lower", {8'h00, data_bus[1:0]}, {8'h00, nt.value[7:6]});
      end
      seen_start = 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, reads of the cleared result, then conversions.
  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    bus_write = 1'b0;
    bus_read = 1'b0;
    bus_addr = 1'b0;
    wait_for_done = 1'b0;
    analog_level = 10'h000;
    seen_start = 1'b0;
    miscompares = 0;
    checked = 0;
    eoc_cnt = 0;
    void'($urandom(39));
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    // Before any conversion the result reads as zero.
    request(1'b0, adc_pkg::ADDR_BASE, 8'h00);
    request(1'b0, adc_pkg::ADDR_ABOVE, 8'h00);
    // Extremes first, then random levels; even rounds use the timer.
    for (int i = 0; i < 8; i++) begin
      lvl = (i == 0) ? 10'h3FF : (i == 1) ? 10'h000 : 10'($urandom);
      analog_level <= lvl;
      wait_for_done <= i[0];
      request(1'b1, adc_pkg::ADDR_ABOVE, 8'h00);
      request(1'b1, adc_pkg::ADDR_BASE, 8'h01);
      if (!i[0]) begin
        check("timer", 10'(lat >= adc_pkg::RESULT_WAIT_CYC), 10'h001);
      end
      // In done mode this read is refused until the recovery ends.
      request(1'b0, adc_pkg::ADDR_BASE, lvl[9:2]);
      if (i[0]) begin
        check("recovery", 10'(wt >= 990), 10'h001);
      end
      request(1'b0, adc_pkg::ADDR_ABOVE, {lvl[1:0], 6'h00});
      check("eoc", 10'(eoc_cnt), 10'(i + 1));
    end
    repeat (4) @(posedge clk_sys);
    give_verdict();
  end
endmodule
`default_nettype wire
